// >>> rtl/grs_pkg.sv
package grs_pkg;
    // ==================================================
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'hc0;
    localparam logic [7:0] ADDR_INTEG_START = 8'hc1;
    localparam logic [7:0] ADDR_READOUT_START = 8'hc2;
    localparam logic [7:0] ADDR_STROBE_ASSERT = 8'hc3;
    localparam logic [7:0] ADDR_STROBE_RELEASE = 8'hc4;
    localparam logic [7:0] ADDR_FLASH_ASSERT = 8'hc5;
    localparam logic [7:0] ADDR_FLASH_RELEASE = 8'hc6;
    // ==================================================
    // control register fields
    localparam int BIT_GRST_EN = 15;
    localparam int BIT_FLASH_CTRL = 2;
    localparam int BIT_STROBE_CTRL = 1;
    localparam int BIT_READOUT_CTRL = 0;
    // ==================================================
    // reset values
    localparam logic [15:0] RST_INTEG_START = 16'h0064;
    localparam logic [15:0] RST_READOUT_START = 16'h0064;
    localparam logic [15:0] RST_STROBE_ASSERT = 16'h0096;
    localparam logic [15:0] RST_STROBE_RELEASE = 16'h00c8;
    localparam logic [15:0] RST_FLASH_ASSERT = 16'h0064;
    localparam logic [15:0] RST_FLASH_RELEASE = 16'h0078;
    // ==================================================
    // timing
    localparam int CNT_W = 24;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_HOLD_NS = 1000;
    localparam int MIN_HOLD_CYC_INT = (MIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] MIN_HOLD_CYC = 8'(MIN_HOLD_CYC_INT < 1 ? 1 : MIN_HOLD_CYC_INT);
    // ==================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GRST = 3'b001,
        ST_INTEG = 3'b010,
        ST_READOUT = 3'b011,
        ST_DONE = 3'b100
    } grs_state_t;

    typedef struct packed {
        logic readout_src;
        logic strobe_ctrl;
        logic flash_ctrl;
        logic [15:0] integ_start;
        logic [15:0] readout_start;
        logic [15:0] strobe_assert;
        logic [15:0] strobe_release;
        logic [15:0] flash_assert;
        logic [15:0] flash_release;
    } grs_cfg_t;
endpackage

// >>> rtl/grs_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// - with the readout-source bit set, readout starts on the falling edge of the external control pin, else at the programmed time.
// - a 24-bit counter counts master clocks from the start of each global reset sequence.
// - when the counter's upper 16 bits reach the integration-start value, global reset drops and integration begins.
// - global reset is always held for a fixed minimum time, however small the integration-start value.
// - the readout-start offset is added to the integration-start value, scaled by 256 and compared with the full counter.
// - reaching that summed threshold ends integration and begins readout.
// - the strobe rises when the counter's upper 16 bits equal the strobe-assert value, reset 0x96.
// - with the strobe-release bit clear, the strobe falls when the upper bits equal the release value, reset 0xc8.
// - integration-start and readout-start values both reset to 0x64.
// - with the strobe-release bit set, the strobe falls at the end of readout instead.
// - writing 1 to the global-reset-enable bit starts a sequence; the bit always reads back 0.
// - the flash rises when the upper 16 counter bits equal the flash-assert value, reset 0x64.
module grs_sequencer (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // sensor side
    input wire logic GRST_CTRL_PIN,
    input wire logic END_OF_READOUT,
    output logic GLOBAL_RESET,
    output logic INTEGRATING,
    output logic READOUT_START,
    output logic READOUT_ACTIVE,
    // light control
    output logic STROBE,
    output logic FLASH
);

    // ==================================================
    // registers
    grs_pkg::grs_cfg_t cfg_ff, nxt_cfg;
    logic [15:0] rdata_ff, nxt_rdata;
    logic start_req;

    // grst enable is a write strobe only, never stored
    assign start_req = REG_WR && (REG_ADDR == grs_pkg::ADDR_CTRL) && REG_WDATA[grs_pkg::BIT_GRST_EN];

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_rdata = rdata_ff;
        if (REG_WR) begin
            // no frame sync: new thresholds steer the very next compare
            case (REG_ADDR)
                grs_pkg::ADDR_CTRL: begin
                    nxt_cfg.readout_src = REG_WDATA[grs_pkg::BIT_READOUT_CTRL];
                    nxt_cfg.strobe_ctrl = REG_WDATA[grs_pkg::BIT_STROBE_CTRL];
                    nxt_cfg.flash_ctrl = REG_WDATA[grs_pkg::BIT_FLASH_CTRL];
                end
                grs_pkg::ADDR_INTEG_START: nxt_cfg.integ_start = REG_WDATA;
                grs_pkg::ADDR_READOUT_START: nxt_cfg.readout_start = REG_WDATA;
                grs_pkg::ADDR_STROBE_ASSERT: nxt_cfg.strobe_assert = REG_WDATA;
                grs_pkg::ADDR_STROBE_RELEASE: nxt_cfg.strobe_release = REG_WDATA;
                grs_pkg::ADDR_FLASH_ASSERT: nxt_cfg.flash_assert = REG_WDATA;
                grs_pkg::ADDR_FLASH_RELEASE: nxt_cfg.flash_release = REG_WDATA;
                default: nxt_cfg = cfg_ff;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                grs_pkg::ADDR_CTRL: begin
                    nxt_rdata = 16'h0000;
                    nxt_rdata[grs_pkg::BIT_READOUT_CTRL] = cfg_ff.readout_src;
                    nxt_rdata[grs_pkg::BIT_STROBE_CTRL] = cfg_ff.strobe_ctrl;
                    nxt_rdata[grs_pkg::BIT_FLASH_CTRL] = cfg_ff.flash_ctrl;
                end
                grs_pkg::ADDR_INTEG_START: nxt_rdata = cfg_ff.integ_start;
                grs_pkg::ADDR_READOUT_START: nxt_rdata = cfg_ff.readout_start;
                grs_pkg::ADDR_STROBE_ASSERT: nxt_rdata = cfg_ff.strobe_assert;
                grs_pkg::ADDR_STROBE_RELEASE: nxt_rdata = cfg_ff.strobe_release;
                grs_pkg::ADDR_FLASH_ASSERT: nxt_rdata = cfg_ff.flash_assert;
                grs_pkg::ADDR_FLASH_RELEASE: nxt_rdata = cfg_ff.flash_release;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_ff.readout_src <= 1'b0;
            cfg_ff.strobe_ctrl <= 1'b0;
            cfg_ff.flash_ctrl <= 1'b0;
            cfg_ff.integ_start <= grs_pkg::RST_INTEG_START;
            cfg_ff.readout_start <= grs_pkg::RST_READOUT_START;
            cfg_ff.strobe_assert <= grs_pkg::RST_STROBE_ASSERT;
            cfg_ff.strobe_release <= grs_pkg::RST_STROBE_RELEASE;
            cfg_ff.flash_assert <= grs_pkg::RST_FLASH_ASSERT;
            cfg_ff.flash_release <= grs_pkg::RST_FLASH_RELEASE;
            rdata_ff <= 16'h0000;
        end else begin
            cfg_ff <= nxt_cfg;
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA = rdata_ff;

    // ==================================================
    // pin synchroniser
    logic pin_meta_ff, pin_sync_ff, pin_prev_ff;
    logic pin_fall;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end else begin
            pin_meta_ff <= GRST_CTRL_PIN;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign pin_fall = pin_prev_ff && !pin_sync_ff;

    // ==================================================
    // sequence state and counter
    grs_pkg::grs_state_t state_ff, nxt_state;
    logic [grs_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [7:0] hold_cnt_ff, nxt_hold_cnt;
    logic strobe_ff, nxt_strobe, strobe_done_ff, nxt_strobe_done;
    logic flash_ff, nxt_flash, flash_done_ff, nxt_flash_done;
    logic grst_ff, integ_ff, ro_start_ff, ro_active_ff;
    logic [15:0] cnt_hi;
    logic [16:0] ro_sum;
    logic hold_done, readout_begun, counting, integ_go, ro_go, ro_end;
    logic strobe_set, strobe_clr, flash_set, flash_clr, seq_on;

    assign cnt_hi = cnt_ff[grs_pkg::CNT_W-1:grs_pkg::CNT_W-16];
    assign ro_sum = {1'b0, cfg_ff.integ_start} + {1'b0, cfg_ff.readout_start};
    // boost circuit needs a floor on the reset pulse
    assign hold_done = hold_cnt_ff == grs_pkg::MIN_HOLD_CYC;
    assign integ_go = (state_ff == grs_pkg::ST_GRST) && hold_done && (cnt_hi >= cfg_ff.integ_start);
    // >= rather than == so a late write or long hold cannot skip readout
    assign ro_go = (state_ff == grs_pkg::ST_INTEG) && (cfg_ff.readout_src ? pin_fall :
                   ({1'b0, cnt_ff} >= {ro_sum, 8'h00}));
    assign ro_end = (state_ff == grs_pkg::ST_READOUT) && END_OF_READOUT;
    assign readout_begun = (state_ff == grs_pkg::ST_READOUT) || (state_ff == grs_pkg::ST_DONE);
    assign seq_on = state_ff != grs_pkg::ST_IDLE;
    assign counting = seq_on && !(readout_begun && strobe_done_ff);
    assign strobe_clr = seq_on && strobe_ff && (cfg_ff.strobe_ctrl ? ro_end :
                        (cnt_hi == cfg_ff.strobe_release));
    assign strobe_set = seq_on && !strobe_ff && !strobe_done_ff && (cnt_hi == cfg_ff.strobe_assert);
    assign flash_clr = seq_on && flash_ff && (cfg_ff.flash_ctrl ? ro_end : (cnt_hi == cfg_ff.flash_release));
    assign flash_set = seq_on && !flash_ff && !flash_done_ff && (cnt_hi == cfg_ff.flash_assert);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_strobe = strobe_ff;
        nxt_strobe_done = strobe_done_ff;
        nxt_flash = flash_ff;
        nxt_flash_done = flash_done_ff;
        if (start_req) begin
            nxt_state = grs_pkg::ST_GRST;
            nxt_cnt = '0;
            nxt_hold_cnt = 8'h00;
            nxt_strobe = 1'b0;
            nxt_strobe_done = 1'b0;
            nxt_flash = 1'b0;
            nxt_flash_done = 1'b0;
        end else begin
            if (counting && (cnt_ff != {grs_pkg::CNT_W{1'b1}})) begin
                nxt_cnt = cnt_ff + 1'b1;
            end
            if ((state_ff == grs_pkg::ST_GRST) && !hold_done) begin
                nxt_hold_cnt = hold_cnt_ff + 8'h01;
            end
            if (strobe_clr) begin
                nxt_strobe = 1'b0;
                nxt_strobe_done = 1'b1;
            end else if (strobe_set) begin
                nxt_strobe = 1'b1;
            end else if (cfg_ff.strobe_ctrl && ro_end) begin
                // strobe never rose: still counts as released
                nxt_strobe_done = 1'b1;
            end
            if (flash_clr) begin
                nxt_flash = 1'b0;
                nxt_flash_done = 1'b1;
            end else if (flash_set) begin
                nxt_flash = 1'b1;
            end
            case (state_ff)
                grs_pkg::ST_IDLE: nxt_state = grs_pkg::ST_IDLE;
                grs_pkg::ST_GRST: if (integ_go) nxt_state = grs_pkg::ST_INTEG;
                grs_pkg::ST_INTEG: if (ro_go) nxt_state = grs_pkg::ST_READOUT;
                grs_pkg::ST_READOUT: if (ro_end) nxt_state = grs_pkg::ST_DONE;
                grs_pkg::ST_DONE: nxt_state = grs_pkg::ST_DONE;
                default: nxt_state = grs_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_ff <= grs_pkg::ST_IDLE;
            cnt_ff <= '0;
            hold_cnt_ff <= 8'h00;
            strobe_ff <= 1'b0;
            strobe_done_ff <= 1'b0;
            flash_ff <= 1'b0;
            flash_done_ff <= 1'b0;
            grst_ff <= 1'b0;
            integ_ff <= 1'b0;
            ro_start_ff <= 1'b0;
            ro_active_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            hold_cnt_ff <= nxt_hold_cnt;
            strobe_ff <= nxt_strobe;
            strobe_done_ff <= nxt_strobe_done;
            flash_ff <= nxt_flash;
            flash_done_ff <= nxt_flash_done;
            grst_ff <= nxt_state == grs_pkg::ST_GRST;
            integ_ff <= nxt_state == grs_pkg::ST_INTEG;
            ro_start_ff <= !start_req && ro_go;
            ro_active_ff <= nxt_state == grs_pkg::ST_READOUT;
        end
    end

    assign GLOBAL_RESET = grst_ff;
    assign INTEGRATING = integ_ff;
    assign READOUT_START = ro_start_ff;
    assign READOUT_ACTIVE = ro_active_ff;
    assign STROBE = strobe_ff;
    assign FLASH = flash_ff;

    // ==================================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_start;
        start_req;
    endsequence
    sequence s_fresh_reset;
        GLOBAL_RESET && (cnt_ff == 24'h000000) && !STROBE && !FLASH;
    endsequence
    // readout start is a one-cycle pulse while readout stays up
    sequence s_readout_pulse;
        READOUT_START && READOUT_ACTIVE ##1 !READOUT_START;
    endsequence
    property p_start_clears;
        s_start |=> s_fresh_reset;
    endproperty

    chk_start_clears: assert property (p_start_clears)
        else $error("start did not clear counter and enter global reset");
    chk_ctrl_readback: assert property (REG_RD && (REG_ADDR == grs_pkg::ADDR_CTRL) |=> !REG_RDATA[15])
        else $error("global reset enable read back as one");
    chk_count_run: assert property (counting && !start_req && (cnt_ff != 24'hffffff) |=>
        cnt_ff == $past(cnt_ff) + 24'h000001)
        else $error("counter did not advance");
    chk_count_stop: assert property (readout_begun && strobe_done_ff && !start_req |=> $stable(cnt_ff))
        else $error("counter ran after readout and strobe release");
    chk_min_hold: assert property ($fell(GLOBAL_RESET) && INTEGRATING |->
        $past(hold_cnt_ff) == grs_pkg::MIN_HOLD_CYC)
        else $error("global reset released before minimum hold");
    chk_integ_release: assert property (integ_go && !start_req |=> INTEGRATING && !GLOBAL_RESET)
        else $error("integration did not start at threshold");
    chk_readout_timed: assert property ((state_ff == grs_pkg::ST_INTEG) && !cfg_ff.readout_src && !start_req &&
        ({1'b0, cnt_ff} >= (({9'h000, cfg_ff.integ_start} + {9'h000, cfg_ff.readout_start}) << 8))
        |=> s_readout_pulse)
        else $error("timed readout start missed");
    chk_readout_pin: assert property ((state_ff == grs_pkg::ST_INTEG) && cfg_ff.readout_src && !start_req &&
        pin_fall |=> READOUT_START)
        else $error("pin driven readout start missed");
    chk_strobe_on: assert property (strobe_set && !strobe_clr && !start_req |=> STROBE)
        else $error("strobe did not assert");
    chk_strobe_off: assert property (STROBE && !cfg_ff.strobe_ctrl && (cnt_hi == cfg_ff.strobe_release)
        && !start_req |=> !STROBE && strobe_done_ff)
        else $error("strobe did not release at time");
    chk_strobe_ro_end: assert property (STROBE && cfg_ff.strobe_ctrl && ro_end && !start_req |=> !STROBE)
        else $error("strobe did not release at end of readout");
    chk_flash_on: assert property (flash_set && !start_req |=> FLASH)
        else $error("flash did not assert");
    chk_reset_vals: assert property ($fell(RST) |-> (cfg_ff.integ_start == 16'h0064) &&
        (cfg_ff.readout_start == 16'h0064))
        else $error("threshold reset value wrong");
    chk_write_now: assert property (REG_WR && (REG_ADDR == grs_pkg::ADDR_INTEG_START) |=>
        cfg_ff.integ_start == $past(REG_WDATA))
        else $error("threshold write not applied at once");
    // a short hold would leave the boost circuit undercharged
    chk_grst_hold: assert property (GLOBAL_RESET && (hold_cnt_ff < grs_pkg::MIN_HOLD_CYC) && !start_req
        |=> GLOBAL_RESET)
        else $error("global reset dropped inside minimum hold");
    // end of readout or a new start request are the only ways out of readout
    chk_ro_done: assert property (READOUT_ACTIVE && END_OF_READOUT && !start_req |=> !READOUT_ACTIVE)
        else $error("readout did not end on end of readout");
    chk_flash_off: assert property (FLASH && !cfg_ff.flash_ctrl && (cnt_hi == cfg_ff.flash_release)
        && !start_req |=> !FLASH)
        else $error("flash did not release at time");
    chk_flash_ro_end: assert property (FLASH && cfg_ff.flash_ctrl && ro_end && !start_req |=> !FLASH)
        else $error("flash did not release at end of readout");

endmodule // grs_sequencer

// >>> verification/grs_array_model.sv
`timescale 1ns/10ps
// ==================================================
// array side: external control pin and end-of-readout pulse
module grs_array_model #(
    parameter int EOR_DLY = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the bench
    input wire logic pin_hold,
    // from the sequencer
    input wire logic readout_active,
    // to the sequencer
    output logic grst_ctrl_pin = 1'b0,
    output logic end_of_readout = 1'b0
);
    logic [7:0] wait_ff;

    // the pin only moves when the bench commands it, so every falling edge is deliberate
    always @(posedge clk) begin
        if (rst) begin
            wait_ff <= 8'h00;
            end_of_readout <= 1'b0;
            grst_ctrl_pin <= 1'b0;
        end else begin
            grst_ctrl_pin <= pin_hold;
            end_of_readout <= 1'b0;
            // one pulse per readout; the counter restarts, so a lingering active level would pulse again EOR_DLY + 1 cycles later
            if (readout_active && !end_of_readout) begin
                if (wait_ff == 8'(EOR_DLY - 1)) begin
                    end_of_readout <= 1'b1;
                    wait_ff <= 8'h00;
                end else begin
                    wait_ff <= wait_ff + 8'h01;
                end
            end else begin
                wait_ff <= 8'h00;
            end
        end
    end
endmodule // grs_array_model

// >>> verification/tb_global_reset_shutter_sequencer.sv
`timescale 1ns/10ps
module tb_global_reset_shutter_sequencer;
    // ==================================================
    // signals
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_RDATA;
    logic GRST_CTRL_PIN, END_OF_READOUT, GLOBAL_RESET, INTEGRATING;
    logic READOUT_START, READOUT_ACTIVE, STROBE, FLASH;
    logic pin_hold = 1'b0;
    int err_total = 0;
    int cmp_count = 0;
    int tick_count = 0;
    int t_int, t_ro, t_sr, t_sf, t_fr, t_drop, k;
    localparam logic [15:0] RV [7] = '{16'h0000, 16'h0064, 16'h0064, 16'h0096, 16'h00c8, 16'h0064, 16'h0078};

    always #50 CLOCK = ~CLOCK;

    grs_sequencer dut_u (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .GRST_CTRL_PIN(GRST_CTRL_PIN),
        .END_OF_READOUT(END_OF_READOUT), .GLOBAL_RESET(GLOBAL_RESET), .INTEGRATING(INTEGRATING),
        .READOUT_START(READOUT_START), .READOUT_ACTIVE(READOUT_ACTIVE), .STROBE(STROBE), .FLASH(FLASH));

    grs_array_model #(.EOR_DLY(20)) partner_u (.clk(CLOCK), .rst(RST), .pin_hold(pin_hold),
        .readout_active(READOUT_ACTIVE), .grst_ctrl_pin(GRST_CTRL_PIN), .end_of_readout(END_OF_READOUT));

    // ==================================================
    // checking and ending
    task automatic tally_and_finish;
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // event times are the bench's own cycle counts, so a window check is enough
    task automatic rng(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, v, lo, hi);
        end
    endtask

    // ==================================================
    // register port
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLOCK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        @(negedge CLOCK);
        chk(REG_RDATA, exp);
    endtask

    // ==================================================
    // one exposure: start, then log when integration, readout start, strobe and flash first rise, and when the strobe falls
    task automatic run_seq(input logic [15:0] ctrl, input int len, input int pin_at, input int mod_at);
        int i;
        wr(grs_pkg::ADDR_CTRL, ctrl);
        pin_hold <= 1'b1;
        t_int = -1;
        t_ro = -1;
        t_sr = -1;
        t_sf = -1;
        t_fr = -1;
        t_drop = -1;
        for (i = 1; i <= len; i++) begin
            @(posedge CLOCK);
            if (i == pin_at) begin
                pin_hold <= 1'b0;
                t_drop = i;
            end
            REG_WR <= (i == mod_at);
            REG_ADDR <= grs_pkg::ADDR_INTEG_START;
            REG_WDATA <= 16'h0002;
            @(negedge CLOCK);
            if (i == 1 || i == 9) chk({15'h0000, GLOBAL_RESET}, 16'h0001);
            if (INTEGRATING === 1'b1 && t_int < 0) t_int = i;
            if (READOUT_START === 1'b1 && t_ro < 0) t_ro = i;
            if (STROBE === 1'b1 && t_sr < 0) t_sr = i;
            if (STROBE === 1'b0 && t_sr >= 0 && t_sf < 0) t_sf = i;
            if (FLASH === 1'b1 && t_fr < 0) t_fr = i;
        end
    endtask

    // a hung handshake or missing event stops here rather than running forever
    always @(posedge CLOCK) begin
        tick_count <= tick_count + 1;
        if (tick_count == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ==================================================
    // main sequence
    initial begin
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        for (k = 0; k < 7; k++) rd(8'hc0 + 8'(k), RV[k]);
        wr(8'hc7, 16'h1234);
        rd(8'hc7, 16'h0000);
        for (k = 1; k < 7; k++) wr(8'hc0 + 8'(k), 16'h0a00 + 16'(k));
        for (k = 1; k < 7; k++) rd(8'hc0 + 8'(k), 16'h0a00 + 16'(k));
        wr(grs_pkg::ADDR_CTRL, 16'hffff);
        rd(grs_pkg::ADDR_CTRL, 16'h0007);
        // short thresholds: hold limited only by the minimum time
        for (k = 1; k < 7; k++) wr(8'hc0 + 8'(k), 16'((k + 1) % 2));
        run_seq(16'h8000, 300, 0, 0);
        rng(t_int, 10, 14);
        rng(t_ro, 256, 260);
        rng(t_sr, 1, 4);
        rng(t_sf, 256, 260);
        rng(t_fr, 1, 4);
        // integration start raised in mid-hold must move integration and readout start, not strobe or flash
        wr(grs_pkg::ADDR_STROBE_ASSERT, 16'h0001);
        wr(grs_pkg::ADDR_STROBE_RELEASE, 16'h0002);
        wr(grs_pkg::ADDR_FLASH_ASSERT, 16'h0001);
        run_seq(16'h8000, 800, 0, 5);
        rng(t_int, 512, 516);
        rng(t_ro, 768, 772);
        rng(t_sr, 256, 260);
        rng(t_sf, 512, 516);
        rng(t_fr, 256, 260);
        // pin-driven readout, strobe and flash held until end of readout
        // integration must begin well before the pin drops, or the edge is ignored
        wr(grs_pkg::ADDR_INTEG_START, 16'h0000);
        wr(grs_pkg::ADDR_READOUT_START, 16'hffff);
        wr(grs_pkg::ADDR_STROBE_ASSERT, 16'h0000);
        wr(grs_pkg::ADDR_STROBE_RELEASE, 16'h0001);
        run_seq(16'h8007, 500, 400, 0);
        rng(t_int, 10, 14);
        rng(t_ro, t_drop + 2, t_drop + 6);
        rng(t_sf, t_ro + 19, t_ro + 26);
        rng(t_fr, 256, 260);
        chk({15'h0000, READOUT_ACTIVE}, 16'h0000);
        tally_and_finish();
    end
endmodule // tb_global_reset_shutter_sequencer
